// ===== hdl/tkr_device.sv
// device end: option registers, operating mode, key outputs and serial report
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module tkr_device
#(
    parameter int NUM_KEYS = 8,
    parameter int STANDBY_CYCLES = tkr_pkg::TKR_STANDBY_CYCLES
)(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // tie-off option pins, high when left open
    input wire logic output_style_select,
    input wire logic deep_standby_select_pin,
    input wire logic use_i2c_options,
    // option register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // sensed key states, 1 = touched
    input wire logic [7:0] key_touched,
    // key, binary, interrupt and power mode outputs
    output logic [7:0] key_out,
    output logic [7:0] key_out_oe,
    output logic [3:0] binary_out,
    output logic irq_n,
    output logic standby,
    output logic deep_standby,
    // serial link
    tkr_link_if.device link
);
    import tkr_pkg::*;

    typedef enum logic [1:0] {TKR_IDLE, TKR_START, TKR_SHIFT} tkr_ser_e;

    logic [7:0] irq_output_style;
    logic [7:0] standby_power_level;
    logic [7:0] key_wake_threshold [0:15];
    logic clk_s1, clk_s2, clk_s3;
    logic [1:0] opt_s1, opt_s2;
    logic [7:0] keys_prev;
    logic [31:0] idle_cnt;
    logic [4:0] bit_idx;
    logic [15:0] frame;
    tkr_ser_e ser_state;
    logic key_change;
    logic serial_mode;
    logic [3:0] frame_bits;
    logic [7:0] keys_n;
    logic [15:0] next_frame;
    logic wake_key;

    // frame assembly
    always_comb
    begin
        keys_n = ~key_touched;
        if (NUM_KEYS <= 4)
        begin
            next_frame = {8'h00, 1'b1, 3'(tkr_count_touched(keys_n, 4)), keys_n[3:0]};
            frame_bits = 4'(TKR_FRAME4_BITS - 1);
        end
        else
        begin
            next_frame = {TKR_STOP_PATTERN, tkr_count_touched(keys_n, 8), keys_n};
            frame_bits = 4'(TKR_FRAME8_BITS - 1);
        end
    end

    assign key_change = (key_touched != keys_prev);
    assign serial_mode = opt_s2[0];
    assign wake_key = |(key_touched & {key_wake_threshold[7][TKR_WAKE_ENABLE_BIT],
        key_wake_threshold[6][TKR_WAKE_ENABLE_BIT], key_wake_threshold[5][TKR_WAKE_ENABLE_BIT],
        key_wake_threshold[4][TKR_WAKE_ENABLE_BIT], key_wake_threshold[3][TKR_WAKE_ENABLE_BIT],
        key_wake_threshold[2][TKR_WAKE_ENABLE_BIT], key_wake_threshold[1][TKR_WAKE_ENABLE_BIT],
        key_wake_threshold[0][TKR_WAKE_ENABLE_BIT]}) | (~use_i2c_options & |key_touched);

    // synchronise pins and link clock
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            clk_s1 <= 1'b1;
            clk_s2 <= 1'b1;
            clk_s3 <= 1'b1;
            opt_s1 <= 2'b11;
            opt_s2 <= 2'b11;
        end
        else
        begin
            clk_s1 <= link.link_clk;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            opt_s1 <= {deep_standby_select_pin, output_style_select};
            opt_s2 <= opt_s1;
        end
    end

    // option registers
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_output_style <= TKR_IRQ_STYLE_RST;
            standby_power_level <= TKR_STANDBY_LEVEL_RST;
            for (int i = 0; i < 16; i++)
            begin
                key_wake_threshold[i] <= TKR_KEY_WAKE_RST;
            end
        end
        else if (reg_write)
        begin
            if (reg_addr == TKR_IRQ_OUTPUT_STYLE_OFS)
            begin
                irq_output_style <= reg_wdata & 8'h01;
            end
            else if (reg_addr == TKR_STANDBY_POWER_LEVEL_OFS)
            begin
                standby_power_level <= reg_wdata & 8'h40;
            end
            else if (reg_addr >= TKR_KEY_WAKE_THRESHOLD_OFS && reg_addr <= TKR_KEY_WAKE_LAST_OFS)
            begin
                key_wake_threshold[4'(reg_addr - TKR_KEY_WAKE_THRESHOLD_OFS)] <= reg_wdata;
            end
        end
    end

    // register read, data one cycle later
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_read)
        begin
            if (reg_addr == TKR_IRQ_OUTPUT_STYLE_OFS)
            begin
                reg_rdata <= irq_output_style;
            end
            else if (reg_addr == TKR_STANDBY_POWER_LEVEL_OFS)
            begin
                reg_rdata <= standby_power_level;
            end
            else if (reg_addr >= TKR_KEY_WAKE_THRESHOLD_OFS && reg_addr <= TKR_KEY_WAKE_LAST_OFS)
            begin
                reg_rdata <= key_wake_threshold[4'(reg_addr - TKR_KEY_WAKE_THRESHOLD_OFS)];
            end
            else
            begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // operating mode: standby after 8 s without touch
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            idle_cnt <= 32'h0000_0000;
            standby <= 1'b0;
            deep_standby <= 1'b0;
        end
        else
        begin
            deep_standby <= use_i2c_options ? standby_power_level[TKR_DEEP_STANDBY_BIT]
                : ~opt_s2[1];
            if (|key_touched)
            begin
                idle_cnt <= 32'h0000_0000;
                if (!standby || wake_key)
                begin
                    standby <= 1'b0;
                end
            end
            else if (idle_cnt >= 32'(STANDBY_CYCLES - 1))
            begin
                standby <= 1'b1;
            end
            else
            begin
                idle_cnt <= idle_cnt + 32'h0000_0001;
            end
        end
    end

    // parallel outputs, interrupt and binary report
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            keys_prev <= 8'h00;
            key_out <= 8'h00;
            key_out_oe <= 8'h00;
            binary_out <= 4'hF;
            irq_n <= 1'b1;
        end
        else
        begin
            keys_prev <= key_touched;
            if (opt_s2[0])
            begin
                key_out <= 8'h00; // drive low only when touched
                key_out_oe <= key_touched;
            end
            else
            begin
                key_out <= key_touched;
                key_out_oe <= 8'hFF;
            end
            // highest output low on any press, rest encode lowest key
            binary_out <= 4'hF;
            for (int i = 7; i >= 0; i--)
            begin
                if (key_touched[i])
                begin
                    binary_out <= {1'b0, ~3'(i)};
                end
            end
            if (irq_output_style[TKR_IRQ_PULSE_BIT])
            begin
                irq_n <= ~key_change; // one-shot
            end
            else
            begin
                irq_n <= ~(|key_touched); // level hold
            end
        end
    end

    // serial report: start low, then shift on master clock
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ser_state <= TKR_IDLE;
            bit_idx <= 5'h00;
            frame <= 16'hFFFF;
            link.data_o <= 1'b0;
            link.data_oe <= 1'b0;
        end
        else
        begin
            case (ser_state)
                TKR_IDLE:
                begin
                    link.data_oe <= 1'b0;
                    if (serial_mode && !clk_s2 && clk_s3)
                    begin
                        frame <= next_frame; // poll
                        link.data_oe <= ~next_frame[0];
                        bit_idx <= 5'h00;
                        ser_state <= TKR_SHIFT;
                    end
                    else if (serial_mode && key_change)
                    begin
                        link.data_oe <= 1'b1;
                        ser_state <= TKR_START;
                    end
                end
                TKR_START:
                begin
                    if (!clk_s2 && clk_s3)
                    begin
                        frame <= next_frame;
                        link.data_oe <= ~next_frame[0]; // bit ready while low
                        bit_idx <= 5'h00;
                        ser_state <= TKR_SHIFT;
                    end
                end
                TKR_SHIFT:
                begin
                    if (!clk_s2 && clk_s3)
                    begin
                        link.data_oe <= ~frame[bit_idx[3:0]];
                    end
                    else if (clk_s2 && !clk_s3)
                    begin
                        if (bit_idx[3:0] == frame_bits)
                        begin
                            ser_state <= TKR_IDLE;
                        end
                        else
                        begin
                            bit_idx <= bit_idx + 5'h01;
                        end
                    end
                end
                default:
                begin
                    ser_state <= TKR_IDLE;
                end
            endcase
        end
    end
endmodule

// ===== hdl/tkr_pkg.sv
// package: constants and the key-count function shared by the touch-key report device and host
// Summary of operation
// - open style pin: open-drain active low outputs
// - open style pin, four or eight keys: serial report
// - open standby pin: ordinary saving, grounded deeper
// - option bit0: level hold or one-shot interrupt
// - option bit6: standby depth, defaults to one
// - per-key register: wake enable plus threshold
// - no touch for 8 s: enter standby
// - touch wakes; standby 8 s after release
// - open-drain outputs idle high, low when touched
// - push-pull outputs idle low, high when touched
// - key change drives data low as start
// - master clocks; device sets bit while low
// - four-key frame takes exactly 8 clocks
// - master may poll without waiting for start
// - after bad read master waits about 6 ms
// - bits 3..0 carry keys, zero means touched
// - bits 6..4 count the touched keys
// - bit 7 is a stop bit of one
// - eight-key frame top nibble is 1010
// - eight-key bits 7..0 keys, 11..8 count
// - binary top output low while any pressed
package tkr_pkg;
    // option register offsets
    localparam logic [7:0] TKR_IRQ_OUTPUT_STYLE_OFS = 8'hB0;
    localparam logic [7:0] TKR_STANDBY_POWER_LEVEL_OFS = 8'hB4;
    localparam logic [7:0] TKR_KEY_WAKE_THRESHOLD_OFS = 8'hB5;
    localparam logic [7:0] TKR_KEY_WAKE_LAST_OFS = 8'hC4;
    // host command/status registers of the controller
    localparam logic [7:0] TKR_HOST_CTRL_OFS = 8'h00;
    localparam logic [7:0] TKR_HOST_STAT_OFS = 8'h04;
    localparam logic [7:0] TKR_HOST_DATA_OFS = 8'h08;
    // field positions
    localparam int TKR_IRQ_PULSE_BIT = 0;
    localparam int TKR_DEEP_STANDBY_BIT = 6;
    localparam int TKR_WAKE_ENABLE_BIT = 7;
    // reset values and the eight-key stop pattern
    localparam logic [7:0] TKR_IRQ_STYLE_RST = 8'h00;
    localparam logic [7:0] TKR_STANDBY_LEVEL_RST = 8'h40;
    localparam logic [7:0] TKR_KEY_WAKE_RST = 8'h10;
    localparam logic [3:0] TKR_STOP_PATTERN = 4'hA;
    // timing
    localparam int TKR_CLK_HZ = 25_000_000;
    localparam int TKR_STANDBY_DELAY_S = 8;
    localparam int TKR_STANDBY_CYCLES = TKR_STANDBY_DELAY_S * TKR_CLK_HZ;
    localparam int TKR_ERROR_WAIT_US = 6000;
    localparam int TKR_ERROR_WAIT_CYCLES = TKR_ERROR_WAIT_US * (TKR_CLK_HZ / 1_000_000);
    localparam int TKR_HALF_PERIOD_NS = 20_000;
    localparam int TKR_HALF_PERIOD_CYCLES = (TKR_HALF_PERIOD_NS + 39) / 40;
    // frame lengths
    localparam int TKR_FRAME4_BITS = 8;
    localparam int TKR_FRAME8_BITS = 16;

    // count of zeros in the lowest n bits of an 8-bit key vector (zero = touched)
    function automatic logic [3:0] tkr_count_touched(input logic [7:0] keys_n, input int n);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (i < n && !keys_n[i])
            begin
                c = c + 4'h1;
            end
        end
        return c;
    endfunction
endpackage

// ===== hdl/tkr_link_if.sv
// interface: two-wire serial report link between device and host
`timescale 1ns/1ps
interface tkr_link_if;
    // clock driven by host, data line open-drain from device with pull-up
    logic link_clk;
    logic data_o;
    logic data_oe;
    logic data_line;
    assign data_line = data_oe ? data_o : 1'b1;
    modport device (input link_clk, output data_o, output data_oe);
    modport host (output link_clk, input data_line);
endinterface

// ===== hdl/tkr_host.sv
// host end: reads the serial key report by driving the link clock
`timescale 1ns/1ps
module tkr_host
#(
    parameter int FRAME_BITS = tkr_pkg::TKR_FRAME4_BITS,
    parameter int ERROR_WAIT_CYCLES = tkr_pkg::TKR_ERROR_WAIT_CYCLES
)(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // software port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic write,
    input wire logic read,
    output logic [31:0] rdata,
    // serial link
    tkr_link_if.host link
);
    import tkr_pkg::*;

    typedef enum logic [1:0] {TKH_IDLE, TKH_LOW, TKH_HIGH, TKH_WAIT} tkh_state_e;

    tkh_state_e state;
    logic d_s1, d_s2;
    logic [15:0] shift;
    logic [15:0] frame;
    logic [4:0] bit_cnt;
    logic [31:0] tmr;
    logic frame_valid;
    logic frame_error;
    logic auto_read;
    logic start_req;
    logic [3:0] cnt;

    // checks a received frame's count and stop fields
    function automatic logic tkh_frame_ok(input logic [15:0] f);
        if (FRAME_BITS == TKR_FRAME4_BITS)
        begin
            return f[7] && (f[6:4] == 3'(tkr_count_touched({4'hF, f[3:0]}, 4)));
        end
        return (f[15:12] == TKR_STOP_PATTERN) && (f[11:8] == tkr_count_touched(f[7:0], 8));
    endfunction

    assign start_req = write && addr == TKR_HOST_CTRL_OFS && wdata[0];

    // synchronise data line
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            d_s1 <= 1'b1;
            d_s2 <= 1'b1;
        end
        else
        begin
            d_s1 <= link.data_line;
            d_s2 <= d_s1;
        end
    end

    // auto-read enable from control register
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            auto_read <= 1'b0;
        end
        else if (write && addr == TKR_HOST_CTRL_OFS)
        begin
            auto_read <= wdata[1];
        end
    end

    // clock generation and bit sampling
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= TKH_IDLE;
            link.link_clk <= 1'b1;
            shift <= 16'h0000;
            frame <= 16'hFFFF;
            bit_cnt <= 5'h00;
            tmr <= 32'h0000_0000;
            frame_valid <= 1'b0;
            frame_error <= 1'b0;
            cnt <= 4'h0;
        end
        else
        begin
            if (read && addr == TKR_HOST_DATA_OFS)
            begin
                frame_valid <= 1'b0;
            end
            case (state)
                TKH_IDLE:
                begin
                    if (start_req || (auto_read && !d_s2)) // poll or start low
                    begin
                        link.link_clk <= 1'b0;
                        bit_cnt <= 5'h00;
                        cnt <= 4'h0;
                        state <= TKH_LOW;
                    end
                end
                TKH_LOW:
                begin
                    if (cnt == 4'(TKR_HALF_PERIOD_CYCLES - 1))
                    begin
                        link.link_clk <= 1'b1;
                        cnt <= 4'h0;
                        state <= TKH_HIGH;
                    end
                    else
                    begin
                        cnt <= cnt + 4'h1;
                    end
                end
                TKH_HIGH:
                begin
                    if (cnt == 4'(TKR_HALF_PERIOD_CYCLES - 1))
                    begin
                        shift <= {d_s2, shift[15:1]}; // sample after rise, lsb first
                        cnt <= 4'h0;
                        if (bit_cnt == 5'(FRAME_BITS - 1))
                        begin
                            frame <= {d_s2, shift[15:1]} >> (16 - FRAME_BITS);
                            frame_valid <= 1'b1;
                            frame_error <= !tkh_frame_ok({d_s2, shift[15:1]} >> (16 - FRAME_BITS));
                            tmr <= 32'h0000_0000;
                            state <= TKH_WAIT;
                        end
                        else
                        begin
                            bit_cnt <= bit_cnt + 5'h01;
                            link.link_clk <= 1'b0;
                            state <= TKH_LOW;
                        end
                    end
                    else
                    begin
                        cnt <= cnt + 4'h1;
                    end
                end
                TKH_WAIT:
                begin
                    // after an error hold off else wait for line release
                    if (!frame_error && d_s2)
                    begin
                        state <= TKH_IDLE;
                    end
                    else if (tmr >= 32'(ERROR_WAIT_CYCLES - 1))
                    begin
                        state <= TKH_IDLE;
                    end
                    else
                    begin
                        tmr <= tmr + 32'h0000_0001;
                    end
                end
                default:
                begin
                    state <= TKH_IDLE;
                end
            endcase
        end
    end

    // status and data readback, one cycle after strobe
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata <= 32'h0000_0000;
        end
        else if (read)
        begin
            if (addr == TKR_HOST_STAT_OFS)
            begin
                rdata <= {28'h0, frame_error, frame_valid, state == TKH_WAIT, state != TKH_IDLE};
            end
            else if (addr == TKR_HOST_DATA_OFS)
            begin
                rdata <= {16'h0000, frame};
            end
            else if (addr == TKR_HOST_CTRL_OFS)
            begin
                rdata <= {30'h0, auto_read, 1'b0};
            end
            else
            begin
                rdata <= 32'h0000_0000;
            end
        end
    end
endmodule

// ===== tb/tkr_link_asserts.sv
// checker: link-level assertions for the serial key report
`timescale 1ns/1ps
module tkr_link_asserts (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // link signals
    input wire logic link_clk,
    input wire logic data_o,
    input wire logic data_oe,
    input wire logic data_line
);
    logic [5:0] high_run;
    logic [4:0] falls;
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    // length of the current high phase of the link clock
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            high_run <= 6'h00;
        else if (!link_clk)
            high_run <= 6'h00;
        else if (high_run != 6'h3F)
            high_run <= high_run + 6'h01;
    end
    // falling edges since the link went idle; a long high phase ends a frame
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            falls <= 5'h00;
        else if ($fell(link_clk))
            falls <= falls + 5'h01;
        else if (high_run == 6'h10)
            falls <= 5'h00;
    end
    a_drive_low_only: assert property (data_oe |-> !data_o)
        else $error("data line driven high");
    a_quiet_after_reset: assert property ($rose(rstn) |-> link_clk && !data_oe)
        else $error("link not idle after reset");
    a_clk_low_min: assert property ($fell(link_clk) |-> !link_clk [*3])
        else $error("link clock low phase too short");
    a_clk_high_min: assert property ($rose(link_clk) |-> link_clk [*3])
        else $error("link clock high phase too short");
    a_bit_steady: assert property ($rose(link_clk) && falls < 5'h08
        |-> ##1 $stable(data_line) [*2])
        else $error("data changed while clock high");
    a_falls_per_frame: assert property ($fell(link_clk) |-> falls < 5'h08)
        else $error("more than eight clocks in a frame");
    a_frame_ends_idle: assert property ($rose(link_clk) && falls == 5'h08 |-> link_clk [*8])
        else $error("clock restarted right after a frame");
    a_stop_bit_high: assert property ($rose(link_clk) && falls == 5'h08 |-> ##2 data_line)
        else $error("stop bit not high");
    // main scenarios
    c_full_frame: cover property ($rose(link_clk) && falls == 5'h08);
    c_start_low: cover property ($fell(data_line) && link_clk && falls == 5'h00);
    c_frame_begin: cover property ($fell(link_clk) && falls == 5'h00);
endmodule

// ===== tb/touch_key_report_interface_test.sv
// testbench: device and host joined over the serial key link
`timescale 1ns/1ps
module touch_key_report_interface_test;
    import tkr_pkg::*;
    localparam int SB_CYC = 1000;
    logic sys_clk, rstn, output_style_select, deep_standby_select_pin, use_i2c_options;
    logic reg_write, reg_read, irq_n, standby, deep_standby, write, read;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, key_touched, key_out, key_out_oe, addr;
    logic [3:0] binary_out;
    logic [31:0] wdata, rdata;
    int miscompares;
    int checks;
    tkr_link_if link ();
    tkr_device #(.NUM_KEYS(4), .STANDBY_CYCLES(SB_CYC)) tkr_device_inst (
        .sys_clk(sys_clk), .rstn(rstn), .output_style_select(output_style_select),
        .deep_standby_select_pin(deep_standby_select_pin), .use_i2c_options(use_i2c_options),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .key_touched(key_touched),
        .key_out(key_out), .key_out_oe(key_out_oe), .binary_out(binary_out),
        .irq_n(irq_n), .standby(standby), .deep_standby(deep_standby), .link(link));
    tkr_host #(.FRAME_BITS(TKR_FRAME4_BITS), .ERROR_WAIT_CYCLES(200)) tkr_host_inst (
        .sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .write(write),
        .read(read), .rdata(rdata), .link(link));
    tkr_link_asserts tkr_link_asserts_inst (
        .sys_clk(sys_clk), .rstn(rstn), .link_clk(link.link_clk), .data_o(link.data_o),
        .data_oe(link.data_oe), .data_line(link.data_line));
    // system clock, 40 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask
    task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask
    task automatic dev_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1;
        chk_val({24'h0, reg_rdata}, {24'h0, exp});
    endtask
    task automatic host_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        write <= 1'b1;
        @(posedge sys_clk);
        write <= 1'b0;
    endtask
    task automatic host_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        read <= 1'b1;
        @(posedge sys_clk);
        read <= 1'b0;
        #1;
        d = rdata;
    endtask
    // start one frame, wait for valid under a bound, fetch it
    task automatic read_frame(output logic [31:0] f);
        logic [31:0] s;
        int n;
        s = 32'h0000_0000;
        n = 0;
        host_wr(TKR_HOST_CTRL_OFS, 32'h0000_0001);
        while (s[2] !== 1'b1 && n < 1000)
        begin
            host_rd(TKR_HOST_STAT_OFS, s);
            n++;
        end
        host_rd(TKR_HOST_DATA_OFS, f);
    endtask
    // stop bit, count of touched keys, key bits low when touched
    function automatic logic [7:0] frame4(input logic [3:0] t);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 0; i < 4; i++)
            c = c + {2'h0, t[i]};
        return {1'b1, c, ~t};
    endfunction
    task automatic final_report();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        miscompares++;
        $display("watchdog expired");
        final_report();
    end
    // main sequence
    initial
    begin
        logic [31:0] f;
        int n;
        {rstn, output_style_select, deep_standby_select_pin, use_i2c_options} = 4'h6;
        {reg_addr, reg_wdata, reg_write, reg_read, key_touched} = 26'h0;
        {addr, wdata, write, read} = 42'h0;
        miscompares = 0;
        checks = 0;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        dev_rd(TKR_IRQ_OUTPUT_STYLE_OFS, TKR_IRQ_STYLE_RST);
        dev_rd(TKR_STANDBY_POWER_LEVEL_OFS, 8'h40);
        dev_rd(TKR_KEY_WAKE_THRESHOLD_OFS, 8'h10);
        dev_rd(8'h10, 8'h00);
        host_rd(8'h0C, f);
        chk_val(f, 32'h0000_0000);
        dev_wr(TKR_IRQ_OUTPUT_STYLE_OFS, 8'hFF);
        dev_rd(TKR_IRQ_OUTPUT_STYLE_OFS, 8'h01);
        dev_wr(8'hB8, 8'h8A);
        dev_rd(8'hB8, 8'h8A);
        dev_wr(TKR_IRQ_OUTPUT_STYLE_OFS, 8'h00);
        $display("test registers done");
        repeat (SB_CYC - 150) @(posedge sys_clk);
        chk_bit(standby, 1'b0);
        repeat (200) @(posedge sys_clk);
        chk_bit(standby, 1'b1);
        chk_bit(deep_standby, 1'b0);
        deep_standby_select_pin <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk_bit(deep_standby, 1'b1);
        deep_standby_select_pin <= 1'b1;
        use_i2c_options <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk_bit(deep_standby, 1'b1);
        dev_wr(TKR_STANDBY_POWER_LEVEL_OFS, 8'h00);
        repeat (4) @(posedge sys_clk);
        chk_bit(deep_standby, 1'b0);
        use_i2c_options <= 1'b0;
        key_touched <= 8'h01;
        repeat (10) @(posedge sys_clk);
        chk_bit(standby, 1'b0);
        chk_bit(irq_n, 1'b0);
        chk_bit(link.data_line, 1'b0);
        chk_val({28'h0, key_out_oe[3:0]}, 32'h0000_0001);
        chk_bit(key_out[0], 1'b0);
        key_touched <= 8'h00;
        repeat (SB_CYC - 100) @(posedge sys_clk);
        chk_bit(standby, 1'b0);
        repeat (200) @(posedge sys_clk);
        chk_bit(standby, 1'b1);
        $display("test power modes done");
        for (int p = 0; p < 16; p++)
        begin
            key_touched <= {4'h0, p[3:0]};
            repeat (20) @(posedge sys_clk);
            read_frame(f);
            chk_val(f, {24'h0, frame4(p[3:0])});
        end
        repeat (20) @(posedge sys_clk);
        chk_bit(link.data_line, 1'b1);
        read_frame(f);
        chk_val(f, {24'h0, frame4(4'hF)});
        $display("test serial frames done");
        dev_wr(TKR_IRQ_OUTPUT_STYLE_OFS, 8'h01);
        key_touched <= 8'h02;
        n = 0;
        repeat (20)
        begin
            @(posedge sys_clk);
            #1;
            if (irq_n === 1'b0)
                n++;
        end
        chk_val(n, 32'h0000_0001);
        output_style_select <= 1'b0;
        key_touched <= 8'h06;
        repeat (5) @(posedge sys_clk);
        chk_val({28'h0, key_out_oe[3:0]}, 32'h0000_000F);
        chk_val({28'h0, key_out[3:0]}, 32'h0000_0006);
        chk_val({28'h0, binary_out}, 32'h0000_0006);
        key_touched <= 8'h00;
        repeat (5) @(posedge sys_clk);
        chk_val({28'h0, key_out[3:0]}, 32'h0000_0000);
        chk_val({28'h0, binary_out}, 32'h0000_000F);
        $display("test output styles done");
        final_report();
    end
endmodule
